// ---- hw/sleep_ctrl_pkg.sv ----
package sleep_ctrl_pkg;

    // register map, byte addresses on the bus
    localparam logic [11:0] SLEEP_CONTROL_ADDR = 12'h000;
    localparam logic [11:0] SLEEP_STATUS_ADDR  = 12'h004;
    localparam logic [11:0] WAKE_ENABLE_ADDR   = 12'h008;
    localparam logic [11:0] WAKE_PENDING_ADDR  = 12'h00C;

    // sleep control field layout
    localparam int          SLEEP_ARM_BIT      = 0;
    localparam int          MODE_LSB           = 1;
    localparam int          MODE_MSB           = 3;
    localparam logic [7:0]  CONTROL_RESET      = 8'h00;
    localparam logic [7:0]  CONTROL_WR_MASK    = 8'h0F;

    // mode codes
    localparam logic [2:0]  MODE_IDLE          = 3'h0;
    localparam logic [2:0]  MODE_QUIET         = 3'h1;
    localparam logic [2:0]  MODE_POWER_DOWN    = 3'h2;
    localparam logic [2:0]  MODE_POWER_SAVE    = 3'h3;
    localparam logic [2:0]  MODE_POWER_OFF     = 3'h4;

    // wake source bit positions
    localparam int          WK_REG_CURRENT     = 0;
    localparam int          WK_PROTECTION      = 1;
    localparam int          WK_EXTERNAL        = 2;
    localparam int          WK_SMBUS           = 3;
    localparam int          WK_WATCHDOG        = 4;
    localparam int          WK_WAKEUP_TIMER    = 5;
    localparam int          WK_MEM_READY       = 6;
    localparam int          WK_CHARGE_CONV     = 7;
    localparam int          WK_VOLT_CONV       = 8;
    localparam int          WK_OTHER_IO        = 9;
    localparam int          WK_CHARGER         = 10;
    localparam int          WAKE_WIDTH         = 11;

    // accepted wake sources per mode
    localparam logic [10:0] WAKE_MASK_IDLE     = 11'h3FF;
    localparam logic [10:0] WAKE_MASK_QUIET    = 11'h1FF;
    localparam logic [10:0] WAKE_MASK_SAVE     = 11'h0BF;
    localparam logic [10:0] WAKE_MASK_DOWN     = 11'h01E;
    localparam logic [10:0] WAKE_MASK_OFF      = 11'h400;

    // module run vector bit positions
    localparam int          RUN_TIMERS         = 0;
    localparam int          RUN_VOLT_CONV      = 1;
    localparam int          RUN_CHARGE_CONV    = 2;
    localparam int          RUN_WAKEUP_TIMER   = 3;
    localparam int          RUN_ULP_OSC        = 4;
    localparam int          RUN_WATCHDOG       = 5;
    localparam int          RUN_PROTECTION     = 6;
    localparam int          RUN_EXT_INT        = 7;
    localparam int          RUN_CHARGER_DET    = 8;
    localparam int          RUN_SUPPLY_REG     = 9;
    localparam int          RUN_WIDTH          = 10;

    // timing counts in cpu clock cycles
    localparam logic [3:0]  AUTO_CLEAR_CYCLES  = 4'h4;
    localparam logic [3:0]  WAKE_STALL_CYCLES  = 4'h4;
    localparam logic [3:0]  STARTUP_CYCLES     = 4'h6;

endpackage : sleep_ctrl_pkg

// ---- hw/power_off_timer.sv ----
`timescale 1ns/100ps
// counts cycles after an arming write in power-off mode
module power_off_timer
#(
    parameter logic [3:0] CYCLES = sleep_ctrl_pkg::AUTO_CLEAR_CYCLES
)
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    output logic      expire_o
);
    logic [3:0] count_reg;

    // restart on each arming write; the count is loaded one short because the
    // registered pulse adds a cycle, so the clear lands CYCLES edges after the write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_reg <= 4'h0;
            expire_o  <= 1'b0;
        end
        else
        begin
            expire_o <= (count_reg == 4'h1) && !start_i;
            if (start_i)
                count_reg <= CYCLES - 4'h1;
            else if (count_reg != 4'h0)
                count_reg <= count_reg - 4'h1;
        end
    end
endmodule : power_off_timer

// ---- hw/mode_decoder.sv ----
`timescale 1ns/100ps
// maps the sleep state to running modules and accepted wake sources
module mode_decoder
(
    input  wire logic        asleep_i,
    input  wire logic [2:0]  mode_i,
    output logic [9:0]       run_o,
    output logic [10:0]      accept_o
);
    // active runs everything except the charger detector
    always_comb
    begin
        run_o    = 10'h2FF;
        accept_o = 11'h000;
        if (asleep_i)
        begin
            case (mode_i)
                sleep_ctrl_pkg::MODE_IDLE:
                begin
                    run_o    = 10'h2FF;
                    accept_o = sleep_ctrl_pkg::WAKE_MASK_IDLE;
                end
                sleep_ctrl_pkg::MODE_QUIET:
                begin
                    run_o    = 10'h2FE;
                    accept_o = sleep_ctrl_pkg::WAKE_MASK_QUIET;
                end
                sleep_ctrl_pkg::MODE_POWER_SAVE:
                begin
                    run_o    = 10'h2FC;
                    accept_o = sleep_ctrl_pkg::WAKE_MASK_SAVE;
                end
                sleep_ctrl_pkg::MODE_POWER_DOWN:
                begin
                    run_o    = 10'h2F0;
                    accept_o = sleep_ctrl_pkg::WAKE_MASK_DOWN;
                end
                default:
                begin
                    run_o    = 10'h300;
                    accept_o = sleep_ctrl_pkg::WAKE_MASK_OFF;
                end
            endcase
        end
    end
endmodule : mode_decoder

// ---- hw/sleep_mode_controller.sv ----
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps
// Contract
// - halt sleeps only when arm bit set
// - bits seven to four read zero
// - mode field bits three to one
// - power-off arm clears register after four cycles
// - code 000 idle stops cpu, memory clocks
// - idle wakes on external and internal interrupts
// - code 001 quiet mode stops peripheral clock
// - code 011 power-save stops fast oscillator
// - power-save wake waits for start-up time
// - code 010 power-down stops fast and low-frequency oscillators, ulp oscillator keeps running
// - code 100 requests regulator power removal
// - module activity follows mode table
// - smbus only wake detection in deep modes
// - short-circuit protection off with discharge fet
// - accepted wake sources depend on mode
// - wake stalls four cycles beyond start-up
// - power-off exits only by charger reset
module sleep_mode_controller
#(
    parameter logic [3:0] STARTUP = sleep_ctrl_pkg::STARTUP_CYCLES
)
(
    input  wire logic        MCLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        HALT_I,
    input  wire logic [10:0] WAKE_SRC_I,
    input  wire logic        DISCHARGE_FET_ON_I,
    output logic             CPU_CLK_EN_O,
    output logic             MEM_CLK_EN_O,
    output logic             IO_CLK_EN_O,
    output logic             FAST_RC_OSC_EN_O,
    output logic             LOW_FREQ_OSC_EN_O,
    output logic             ULP_OSC_EN_O,
    output logic      [9:0]  MODULE_RUN_O,
    output logic             SMBUS_WAKE_ONLY_O,
    output logic             SHORT_PROT_EN_O,
    output logic             POWER_OFF_REQ_O,
    output logic             WAKE_IRQ_O
);
    typedef enum logic [4:0]
    {
        ST_ACTIVE = 5'b00001,
        ST_SLEEP  = 5'b00010,
        ST_START  = 5'b00100,
        ST_STALL  = 5'b01000,
        ST_OFF    = 5'b10000
    } state_type;

    state_type   state_reg;
    logic [7:0]  control_reg;
    logic [10:0] wake_en_reg;
    logic [10:0] pending_reg;
    logic [2:0]  sleep_mode_reg;
    logic [3:0]  wait_reg;
    logic        access;
    logic        wr_en;
    logic        arm_pulse;
    logic        auto_clear;
    logic        sleep_arm;
    logic [2:0]  sleep_mode_select;
    logic        mode_legal;
    logic [9:0]  run;
    logic [10:0] accept;
    logic [10:0] wake_hit;

    assign sleep_arm         = control_reg[sleep_ctrl_pkg::SLEEP_ARM_BIT];
    assign sleep_mode_select = control_reg[sleep_ctrl_pkg::MODE_MSB:sleep_ctrl_pkg::MODE_LSB];
    assign mode_legal        = sleep_mode_select <= sleep_ctrl_pkg::MODE_POWER_OFF;
    assign access            = PSEL_I && PENABLE_I;
    assign wr_en             = access && PWRITE_I && PREADY_O;
    assign wake_hit          = WAKE_SRC_I & accept & wake_en_reg;

    // an arming write with power-off selected starts the auto-clear count
    assign arm_pulse = wr_en && (PADDR_I == sleep_ctrl_pkg::SLEEP_CONTROL_ADDR)
                       && PWDATA_I[sleep_ctrl_pkg::SLEEP_ARM_BIT]
                       && (PWDATA_I[3:1] == sleep_ctrl_pkg::MODE_POWER_OFF);

    power_off_timer #(.CYCLES(sleep_ctrl_pkg::AUTO_CLEAR_CYCLES)) u_timer
    (
        .clk_i    (MCLK_I),
        .rst_i    (SYS_RST_I),
        .start_i  (arm_pulse),
        .expire_o (auto_clear)
    );

    mode_decoder u_decode
    (
        .asleep_i (state_reg != ST_ACTIVE && state_reg != ST_STALL && state_reg != ST_START),
        .mode_i   (sleep_mode_reg),
        .run_o    (run),
        .accept_o (accept)
    );

    // apb ready: one wait state, answer in the second access cycle after setup
    always_ff @(posedge MCLK_I)
    begin
        if (SYS_RST_I)
            PREADY_O <= 1'b0;
        else
            PREADY_O <= access && !PREADY_O;
    end

    // read data and error for unmapped addresses
    always_ff @(posedge MCLK_I)
    begin
        if (SYS_RST_I)
        begin
            PRDATA_O  <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end
        else if (access && !PREADY_O)
        begin
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
            if (PADDR_I == sleep_ctrl_pkg::SLEEP_CONTROL_ADDR)
                PRDATA_O <= {24'h00_0000, 4'h0, control_reg[3:0]};
            else if (PADDR_I == sleep_ctrl_pkg::SLEEP_STATUS_ADDR)
                PRDATA_O <= {24'h00_0000, sleep_mode_reg, state_reg};
            else if (PADDR_I == sleep_ctrl_pkg::WAKE_ENABLE_ADDR)
                PRDATA_O <= {21'h00_0000, wake_en_reg};
            else if (PADDR_I == sleep_ctrl_pkg::WAKE_PENDING_ADDR)
                PRDATA_O <= {21'h00_0000, pending_reg};
            else
                PSLVERR_O <= 1'b1;
        end
    end

    // sleep control register; the auto-clear wins over nothing else pending
    always_ff @(posedge MCLK_I)
    begin
        if (SYS_RST_I)
            control_reg <= sleep_ctrl_pkg::CONTROL_RESET;
        else if (wr_en && PADDR_I == sleep_ctrl_pkg::SLEEP_CONTROL_ADDR)
            control_reg <= PWDATA_I[7:0] & sleep_ctrl_pkg::CONTROL_WR_MASK;
        else if (auto_clear)
            control_reg <= sleep_ctrl_pkg::CONTROL_RESET;
    end

    // wake source enables
    always_ff @(posedge MCLK_I)
    begin
        if (SYS_RST_I)
            wake_en_reg <= 11'h7FF;
        else if (wr_en && PADDR_I == sleep_ctrl_pkg::WAKE_ENABLE_ADDR)
            wake_en_reg <= PWDATA_I[10:0];
    end

    // pending wake causes; a new hit wins over a software clear
    always_ff @(posedge MCLK_I)
    begin
        if (SYS_RST_I)
            pending_reg <= 11'h000;
        else if (wr_en && PADDR_I == sleep_ctrl_pkg::WAKE_PENDING_ADDR)
            pending_reg <= (pending_reg & ~PWDATA_I[10:0]) | wake_hit;
        else
            pending_reg <= pending_reg | wake_hit;
    end

    // sleep sequencer
    always_ff @(posedge MCLK_I)
    begin
        if (SYS_RST_I)
        begin
            state_reg      <= ST_ACTIVE;
            sleep_mode_reg <= sleep_ctrl_pkg::MODE_IDLE;
            wait_reg       <= 4'h0;
        end
        else
        begin
            case (state_reg)
                ST_ACTIVE:
                begin
                    if (HALT_I && sleep_arm && mode_legal)
                    begin
                        sleep_mode_reg <= sleep_mode_select;
                        if (sleep_mode_select == sleep_ctrl_pkg::MODE_POWER_OFF)
                            state_reg <= ST_OFF;
                        else
                            state_reg <= ST_SLEEP;
                    end
                end
                ST_SLEEP:
                begin
                    if (wake_hit != 11'h000)
                    begin
                        if (sleep_mode_reg == sleep_ctrl_pkg::MODE_POWER_SAVE ||
                            sleep_mode_reg == sleep_ctrl_pkg::MODE_POWER_DOWN)
                        begin
                            state_reg <= ST_START;
                            wait_reg  <= STARTUP;
                        end
                        else
                        begin
                            state_reg <= ST_STALL;
                            wait_reg  <= sleep_ctrl_pkg::WAKE_STALL_CYCLES;
                        end
                    end
                end
                ST_START:
                begin
                    wait_reg <= wait_reg - 4'h1;
                    if (wait_reg == 4'h1)
                    begin
                        state_reg <= ST_STALL;
                        wait_reg  <= sleep_ctrl_pkg::WAKE_STALL_CYCLES;
                    end
                end
                ST_STALL:
                begin
                    wait_reg <= wait_reg - 4'h1;
                    if (wait_reg == 4'h1)
                        state_reg <= ST_ACTIVE;
                end
                ST_OFF:
                    state_reg <= ST_OFF;
                default:
                    state_reg <= ST_ACTIVE;
            endcase
        end
    end

    // clock and module gating outputs, all registered
    always_ff @(posedge MCLK_I)
    begin
        if (SYS_RST_I)
        begin
            CPU_CLK_EN_O      <= 1'b1;
            MEM_CLK_EN_O      <= 1'b1;
            IO_CLK_EN_O       <= 1'b1;
            FAST_RC_OSC_EN_O  <= 1'b1;
            LOW_FREQ_OSC_EN_O <= 1'b1;
            ULP_OSC_EN_O      <= 1'b1;
            MODULE_RUN_O      <= 10'h2FF;
            SMBUS_WAKE_ONLY_O <= 1'b0;
            SHORT_PROT_EN_O   <= 1'b0;
            POWER_OFF_REQ_O   <= 1'b0;
            WAKE_IRQ_O        <= 1'b0;
        end
        else
        begin
            CPU_CLK_EN_O      <= state_reg == ST_ACTIVE;
            MEM_CLK_EN_O      <= state_reg == ST_ACTIVE;
            IO_CLK_EN_O       <= run[sleep_ctrl_pkg::RUN_TIMERS];
            FAST_RC_OSC_EN_O  <= run[sleep_ctrl_pkg::RUN_VOLT_CONV];
            LOW_FREQ_OSC_EN_O <= run[sleep_ctrl_pkg::RUN_WAKEUP_TIMER];
            ULP_OSC_EN_O      <= run[sleep_ctrl_pkg::RUN_ULP_OSC];
            MODULE_RUN_O      <= run;
            SMBUS_WAKE_ONLY_O <= !run[sleep_ctrl_pkg::RUN_TIMERS]
                                 && run[sleep_ctrl_pkg::RUN_EXT_INT];
            SHORT_PROT_EN_O   <= run[sleep_ctrl_pkg::RUN_PROTECTION]
                                 && DISCHARGE_FET_ON_I;
            POWER_OFF_REQ_O   <= state_reg == ST_OFF;
            WAKE_IRQ_O        <= state_reg == ST_STALL && wait_reg == 4'h1;
        end
    end

    chk_halt_unarmed: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        state_reg == ST_ACTIVE && HALT_I && !sleep_arm |=> state_reg == ST_ACTIVE)
        else $error("halt without arm left active");
    chk_reserved_zero: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        control_reg[7:4] == 4'h0)
        else $error("reserved control bits set");
    chk_auto_clear: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        arm_pulse ##1 !(wr_en && PADDR_I == sleep_ctrl_pkg::SLEEP_CONTROL_ADDR) [*4]
        |=> control_reg == 8'h00)
        else $error("power-off arm not auto cleared");
    chk_idle_clock: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        state_reg == ST_SLEEP |=> !CPU_CLK_EN_O)
        else $error("cpu clock runs during sleep");
    chk_wake_filter: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        state_reg == ST_SLEEP && sleep_mode_reg == sleep_ctrl_pkg::MODE_POWER_DOWN
        && (WAKE_SRC_I & sleep_ctrl_pkg::WAKE_MASK_DOWN) == 11'h000 |=> state_reg == ST_SLEEP)
        else $error("power-down woke on refused source");
    chk_stall_len: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        $rose(state_reg == ST_STALL) |-> (state_reg == ST_STALL) [*4] ##1 state_reg == ST_ACTIVE)
        else $error("wake stall not four cycles");
    chk_off_sticky: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        state_reg == ST_OFF |=> state_reg == ST_OFF)
        else $error("power-off left without reset");
    chk_short_prot: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        !DISCHARGE_FET_ON_I |=> !SHORT_PROT_EN_O)
        else $error("short protection on with fet off");

    // wake-up sequencing, power-off request and sleep control clearing
    chk_start_len: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        $rose(state_reg == ST_START) |-> (state_reg == ST_START) [*6] ##1 state_reg == ST_STALL)
        else $error("start-up delay not six cycles");
    chk_off_request: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        state_reg == ST_OFF |=> POWER_OFF_REQ_O && !CPU_CLK_EN_O)
        else $error("power-off entered without regulator request");
    chk_wake_pulse: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        WAKE_IRQ_O |=> !WAKE_IRQ_O)
        else $error("wake interrupt longer than one cycle");
    chk_clear_timing: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        arm_pulse ##1 !(wr_en && PADDR_I == sleep_ctrl_pkg::SLEEP_CONTROL_ADDR) [*3]
        |=> control_reg[sleep_ctrl_pkg::SLEEP_ARM_BIT])
        else $error("power-off arm cleared too early");
    chk_reset_clear: assert property (@(posedge MCLK_I)
        SYS_RST_I |=> control_reg == 8'h00)
        else $error("reset left sleep control set");

    // clock and module enables per sleep mode
    chk_quiet_io: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        state_reg == ST_SLEEP && sleep_mode_reg == sleep_ctrl_pkg::MODE_QUIET
        |=> !IO_CLK_EN_O && FAST_RC_OSC_EN_O && SMBUS_WAKE_ONLY_O)
        else $error("quiet mode clock enables wrong");
    chk_save_osc: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        state_reg == ST_SLEEP && sleep_mode_reg == sleep_ctrl_pkg::MODE_POWER_SAVE
        |=> !FAST_RC_OSC_EN_O && LOW_FREQ_OSC_EN_O && ULP_OSC_EN_O)
        else $error("power-save oscillator enables wrong");
    chk_down_osc: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        state_reg == ST_SLEEP && sleep_mode_reg == sleep_ctrl_pkg::MODE_POWER_DOWN
        |=> !FAST_RC_OSC_EN_O && !LOW_FREQ_OSC_EN_O && ULP_OSC_EN_O)
        else $error("power-down oscillator enables wrong");
    chk_down_run: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        state_reg == ST_SLEEP && sleep_mode_reg == sleep_ctrl_pkg::MODE_POWER_DOWN
        |=> MODULE_RUN_O == 10'h2F0 && SMBUS_WAKE_ONLY_O)
        else $error("power-down module run vector wrong");

    // main scenarios reached
    cov_idle_wake: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        state_reg == ST_SLEEP && sleep_mode_reg == sleep_ctrl_pkg::MODE_IDLE
        ##1 state_reg == ST_STALL);
    cov_quiet_wake: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        state_reg == ST_SLEEP && sleep_mode_reg == sleep_ctrl_pkg::MODE_QUIET
        ##1 state_reg == ST_STALL);
    cov_auto_clear: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        auto_clear);
    cov_save_wake: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        state_reg == ST_START ##[1:20] state_reg == ST_ACTIVE);
    cov_power_off: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        state_reg == ST_OFF);
endmodule : sleep_mode_controller

// ---- dv/sleep_mode_controller_tb.sv ----
`timescale 1ns/100ps
// self-checking bench for the sleep mode controller
module sleep_mode_controller_tb;

    logic        mclk    = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic        halt    = 1'b0;
    logic [10:0] wake    = 11'h000;
    logic        fet_on  = 1'b1;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cpu_en;
    logic        mem_en;
    logic        io_en;
    logic        fast_en;
    logic        low_en;
    logic        ulp_en;
    logic [9:0]  run;
    logic        smbus_only;
    logic        short_en;
    logic        off_req;
    logic        wake_irq;
    logic [31:0] rd;
    logic        er;
    int          bad_count = 0;
    int          n_checks  = 0;

    // 250 MHz clock
    always #2 mclk = ~mclk;

    sleep_mode_controller dut_u (
        .MCLK_I(mclk), .SYS_RST_I(sys_rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .HALT_I(halt), .WAKE_SRC_I(wake),
        .DISCHARGE_FET_ON_I(fet_on), .CPU_CLK_EN_O(cpu_en), .MEM_CLK_EN_O(mem_en),
        .IO_CLK_EN_O(io_en), .FAST_RC_OSC_EN_O(fast_en), .LOW_FREQ_OSC_EN_O(low_en),
        .ULP_OSC_EN_O(ulp_en), .MODULE_RUN_O(run), .SMBUS_WAKE_ONLY_O(smbus_only),
        .SHORT_PROT_EN_O(short_en), .POWER_OFF_REQ_O(off_req), .WAKE_IRQ_O(wake_irq)
    );

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    // compares one value, zero extended to a word
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : wait_cyc

    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // wait for the slave; only the watchdog ends a hung transfer
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pulse_halt;
        @(posedge mclk);
        halt <= 1'b1;
        @(posedge mclk);
        halt <= 1'b0;
    endtask : pulse_halt

    function automatic logic [31:0] clk_vec();
        return {25'h0, cpu_en, mem_en, io_en, fast_en, low_en, ulp_en, smbus_only};
    endfunction : clk_vec

    // enter one mode, try refused sources, then wake and time the delay to the wake interrupt
    task automatic sleep_cycle(input logic [2:0] m, input logic [6:0] clk_exp,
                               input logic [9:0] run_exp, input logic [10:0] bad,
                               input logic [10:0] good, input int lat);
        int cnt;
        apb(1'b1, sleep_ctrl_pkg::SLEEP_CONTROL_ADDR, {28'h0, m, 1'b1});
        pulse_halt();
        wait_cyc(4);
        chk(clk_vec(), {25'h0, clk_exp});
        chk({22'h0, run}, {22'h0, run_exp});
        wake <= bad;
        wait_cyc(20);
        chk({31'h0, cpu_en}, 32'h0);
        wake <= good;
        cnt = 0;
        while (cnt < 60 && wake_irq !== 1'b1)
        begin
            @(posedge mclk);
            cnt++;
        end
        chk({31'h0, cnt >= lat && cnt <= lat + 4}, 32'h1);
        wake <= 11'h000;
        wait_cyc(3);
        chk({31'h0, cpu_en}, 32'h1);
        apb(1'b1, sleep_ctrl_pkg::WAKE_PENDING_ADDR, 32'h0000_07FF);
        apb(1'b1, sleep_ctrl_pkg::SLEEP_CONTROL_ADDR, 32'h0000_0000);
    endtask : sleep_cycle

    // register fields, reserved bits, unmapped address and refused halts
    task automatic test_regs;
        int c;
        apb(1'b0, sleep_ctrl_pkg::SLEEP_CONTROL_ADDR, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b0, sleep_ctrl_pkg::WAKE_ENABLE_ADDR, 32'h0);
        chk(rd, 32'h0000_07FF);
        apb(1'b1, sleep_ctrl_pkg::SLEEP_CONTROL_ADDR, 32'h0000_00FF);
        apb(1'b0, sleep_ctrl_pkg::SLEEP_CONTROL_ADDR, 32'h0);
        chk(rd, 32'h0000_000F);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0000_0000);
        for (c = 5; c < 8; c++)
        begin
            apb(1'b1, sleep_ctrl_pkg::SLEEP_CONTROL_ADDR, {28'h0, 3'(c), 1'b1});
            pulse_halt();
            wait_cyc(4);
            chk({31'h0, cpu_en}, 32'h1);
        end
        apb(1'b1, sleep_ctrl_pkg::SLEEP_CONTROL_ADDR,
            {28'h0, sleep_ctrl_pkg::MODE_POWER_DOWN, 1'b0});
        pulse_halt();
        wait_cyc(4);
        chk(clk_vec(), 32'h0000_007E);
    endtask : test_regs

    // short-circuit protection follows the discharge switch
    task automatic test_fet;
        fet_on <= 1'b0;
        wait_cyc(3);
        chk({31'h0, short_en}, 32'h0);
        fet_on <= 1'b1;
        wait_cyc(3);
        chk({31'h0, short_en}, 32'h1);
    endtask : test_fet

    // auto clear, late halt refused, prompt halt enters power-off for good
    task automatic test_power_off;
        logic [31:0] arm_off;
        arm_off = {28'h0, sleep_ctrl_pkg::MODE_POWER_OFF, 1'b1};
        apb(1'b1, sleep_ctrl_pkg::SLEEP_CONTROL_ADDR, arm_off);
        apb(1'b0, sleep_ctrl_pkg::SLEEP_CONTROL_ADDR, 32'h0);
        chk(rd, 32'h0000_0009);
        wait_cyc(6);
        apb(1'b0, sleep_ctrl_pkg::SLEEP_CONTROL_ADDR, 32'h0);
        chk(rd, 32'h0000_0000);
        pulse_halt();
        wait_cyc(4);
        chk({31'h0, off_req}, 32'h0);
        apb(1'b1, sleep_ctrl_pkg::SLEEP_CONTROL_ADDR, arm_off);
        pulse_halt();
        wait_cyc(4);
        chk({31'h0, off_req}, 32'h1);
        chk(clk_vec(), 32'h0000_0000);
        chk({22'h0, run}, 32'h0000_0300);
        wake <= 11'h7FF;
        wait_cyc(30);
        chk({31'h0, off_req}, 32'h1);
        chk({31'h0, cpu_en}, 32'h0);
        wake <= 11'h000;
    endtask : test_power_off

    // hang guard
    initial
    begin
        repeat (20000) @(posedge mclk);
        $display("watchdog expired at %0t", $time);
        bad_count++;
        give_verdict();
    end

    // main sequence
    initial
    begin
        wait_cyc(16);
        sys_rst <= 1'b0;
        test_regs();
        test_fet();
        sleep_cycle(sleep_ctrl_pkg::MODE_IDLE, 7'h1E, 10'h2FF, 11'h000, 11'h200, 4);
        sleep_cycle(sleep_ctrl_pkg::MODE_QUIET, 7'h0F, 10'h2FE, 11'h600, 11'h080, 4);
        sleep_cycle(sleep_ctrl_pkg::MODE_POWER_SAVE, 7'h07, 10'h2FC, 11'h540, 11'h020, 10);
        sleep_cycle(sleep_ctrl_pkg::MODE_POWER_DOWN, 7'h03, 10'h2F0, 11'h7E1, 11'h004, 10);
        test_power_off();
        sys_rst <= 1'b1;
        wait_cyc(16);
        sys_rst <= 1'b0;
        wait_cyc(2);
        chk(clk_vec(), 32'h0000_007E);
        chk({31'h0, off_req}, 32'h0);
        apb(1'b0, sleep_ctrl_pkg::SLEEP_CONTROL_ADDR, 32'h0);
        chk(rd, 32'h0000_0000);
        give_verdict();
    end

endmodule : sleep_mode_controller_tb
